//--- core/vecctx_defs.vh
// constants for the vector and context system-control register bank
`ifndef VECCTX_DEFS_VH
`define VECCTX_DEFS_VH
// register select codes out of the move decoder
`define SEL_NONE 4'h0
`define SEL_VBASE 4'h1
`define SEL_MON_BASE 4'h2
`define SEL_VIRT_IRQ 4'h3
`define SEL_FAST_PID 4'h4
`define SEL_CONTEXT 4'h5
`define SEL_THREAD_URW 4'h6
`define SEL_THREAD_URO 4'h7
`define SEL_THREAD_PRW 4'h8
`define SEL_CFG_BASE 4'h9
`define SEL_TLB_RD_IDX 4'hA
`define SEL_TLB_WR_IDX 4'hB
`define SEL_TLB_VTAG 4'hC
`define SEL_TLB_PA 4'hD
`define SEL_TLB_ATTR 4'hE
// coprocessor register numbers
`define CRN_VECTOR 4'hC
`define CRN_CONTEXT 4'hD
`define CRN_IMPL 4'hF
`define OPC1_LOCKDOWN 3'h5
// base field and masks
`define BASE_MASK 32'hFFFFFFE0
`define VIRT_ABORT_BIT 8
`define VIRT_IRQ_BIT 7
`define VIRT_FIQ_BIT 6
`define VIRT_MASK 32'h000001C0
`define TLB_VTAG_MASK 32'hFFFFF7FF
`define TLB_ATTR_MASK 32'h00000FFF
`define SPACE_GLOBAL_CODE 10'h200
// reset values and fixed addresses
`define VBASE_SECURE_RESET 32'h00000000
`define CFG_BASE_VALUE 32'h00000000
`define HIGH_VECTOR_BASE 32'hFFFF0000
`define RESET_VECTOR_ADDR 32'h00000000
// lockdown store depth
`define TLB_IDX_W 3
`define TLB_ENTRIES 8
// exception kinds
`define EXC_RESET 3'h0
`define EXC_UNDEF 3'h1
`define EXC_SVC 3'h2
`define EXC_PABORT 3'h3
`define EXC_DABORT 3'h4
`define EXC_IRQ 3'h5
`define EXC_FIQ 3'h6
`define EXC_MON_CALL 3'h7
`endif

//--- core/exc_vector_former.v
// exception branch target formation from the three vector bases
`timescale 1ns/100ps
`include "vecctx_defs.vh"
module exc_vector_former
(
	// clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// exception request
	input wire exc_valid_i,
	input wire [2:0] exc_kind_i,
	input wire exc_external_i,
	input wire secure_i,
	input wire high_vectors_i,
	input wire route_irq_mon_i,
	input wire route_fiq_mon_i,
	input wire route_abort_mon_i,
	// bases from the register bank
	input wire [31:0] vbase_secure_i,
	input wire [31:0] vbase_nonsecure_i,
	input wire [31:0] mon_base_i,
	// result
	output reg target_valid_o,
	output reg target_monitor_o,
	output reg [31:0] target_addr_o
);
	// fixed offset of each exception inside a vector table
	function [31:0] vec_offset;
		input [2:0] kind;
		begin
			case (kind)
				`EXC_RESET: vec_offset = 32'h00000000;
				`EXC_UNDEF: vec_offset = 32'h00000004;
				`EXC_SVC: vec_offset = 32'h00000008;
				`EXC_MON_CALL: vec_offset = 32'h00000008;
				`EXC_PABORT: vec_offset = 32'h0000000C;
				`EXC_DABORT: vec_offset = 32'h00000010;
				`EXC_IRQ: vec_offset = 32'h00000018;
				`EXC_FIQ: vec_offset = 32'h0000001C;
				default: vec_offset = 32'h00000000;
			endcase
		end
	endfunction

	wire is_abort;
	wire to_monitor;
	reg [31:0] next_target;

	// only these causes may take the monitor table
	assign is_abort = (exc_kind_i == `EXC_PABORT) ||
		(exc_kind_i == `EXC_DABORT);
	assign to_monitor = (exc_kind_i == `EXC_MON_CALL) ||
		((exc_kind_i == `EXC_IRQ) && route_irq_mon_i) ||
		((exc_kind_i == `EXC_FIQ) && route_fiq_mon_i) ||
		(is_abort && exc_external_i && route_abort_mon_i);

	// choose base; high vectors override world bases, not monitor
	always @*
	begin
		next_target = `RESET_VECTOR_ADDR;
		if (to_monitor)
			next_target = (mon_base_i & `BASE_MASK) +
				vec_offset(exc_kind_i);
		else if (high_vectors_i)
			next_target = `HIGH_VECTOR_BASE +
				vec_offset(exc_kind_i);
		else if (exc_kind_i == `EXC_RESET)
			next_target = `RESET_VECTOR_ADDR;
		else if (secure_i)
			next_target = (vbase_secure_i & `BASE_MASK) +
				vec_offset(exc_kind_i);
		else
			next_target = (vbase_nonsecure_i & `BASE_MASK) +
				vec_offset(exc_kind_i);
	end

	// one cycle from request to a registered target
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			target_valid_o <= 1'b0;
			target_monitor_o <= 1'b0;
			target_addr_o <= 32'h00000000;
		end
		else
		begin
			target_valid_o <= exc_valid_i;
			if (exc_valid_i)
			begin
				target_monitor_o <= to_monitor;
				target_addr_o <= next_target;
			end
		end
	end
endmodule

//--- core/vector_context_sysctl_regs.v
// vector, context, thread id and tlb lockdown system-control registers
`timescale 1ns/100ps
`include "vecctx_defs.vh"
module vector_context_sysctl_regs
(
	// clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// coprocessor move from the pipeline
	input wire cp_valid_i,
	input wire cp_write_i,
	input wire [2:0] cp_opc1_i,
	input wire [3:0] cp_crn_i,
	input wire [3:0] cp_crm_i,
	input wire [2:0] cp_opc2_i,
	input wire [31:0] cp_wdata_i,
	// processor state
	input wire privileged_i,
	input wire secure_i,
	input wire secure_write_lock_input_i,
	input wire high_vectors_i,
	// exception request
	input wire exc_valid_i,
	input wire [2:0] exc_kind_i,
	input wire exc_external_i,
	input wire route_irq_mon_i,
	input wire route_fiq_mon_i,
	input wire route_abort_mon_i,
	// move answer
	output reg cp_done_o,
	output reg cp_undef_o,
	output reg [31:0] cp_rdata_o,
	// exception target
	output wire target_valid_o,
	output wire target_monitor_o,
	output wire [31:0] target_addr_o,
	// virtual events and context
	output reg pending_guest_abort_o,
	output reg pending_guest_irq_o,
	output reg pending_guest_fiq_o,
	output reg [7:0] address_space_tag_o,
	output reg [31:0] context_identifier_o
);
	// picks the register that a move names
	function [3:0] decode_sel;
		input [2:0] opc1;
		input [3:0] crn;
		input [3:0] crm;
		input [2:0] opc2;
		reg [13:0] key;
		begin
			key = {opc1, crn, crm, opc2};
			case (key)
				{3'h0, `CRN_VECTOR, 4'h0, 3'h0}: decode_sel = `SEL_VBASE;
				{3'h0, `CRN_VECTOR, 4'h0, 3'h1}: decode_sel = `SEL_MON_BASE;
				{3'h0, `CRN_VECTOR, 4'h1, 3'h1}: decode_sel = `SEL_VIRT_IRQ;
				{3'h0, `CRN_CONTEXT, 4'h0, 3'h0}: decode_sel = `SEL_FAST_PID;
				{3'h0, `CRN_CONTEXT, 4'h0, 3'h1}: decode_sel = `SEL_CONTEXT;
				{3'h0, `CRN_CONTEXT, 4'h0, 3'h2}:
					decode_sel = `SEL_THREAD_URW;
				{3'h0, `CRN_CONTEXT, 4'h0, 3'h3}:
					decode_sel = `SEL_THREAD_URO;
				{3'h0, `CRN_CONTEXT, 4'h0, 3'h4}:
					decode_sel = `SEL_THREAD_PRW;
				{3'h0, `CRN_IMPL, 4'h4, 3'h0}: decode_sel = `SEL_CFG_BASE;
				{`OPC1_LOCKDOWN, `CRN_IMPL, 4'h4, 3'h2}:
					decode_sel = `SEL_TLB_RD_IDX;
				{`OPC1_LOCKDOWN, `CRN_IMPL, 4'h4, 3'h4}:
					decode_sel = `SEL_TLB_WR_IDX;
				{`OPC1_LOCKDOWN, `CRN_IMPL, 4'h5, 3'h2}:
					decode_sel = `SEL_TLB_VTAG;
				{`OPC1_LOCKDOWN, `CRN_IMPL, 4'h6, 3'h2}:
					decode_sel = `SEL_TLB_PA;
				{`OPC1_LOCKDOWN, `CRN_IMPL, 4'h7, 3'h2}:
					decode_sel = `SEL_TLB_ATTR;
				default: decode_sel = `SEL_NONE;
			endcase
		end
	endfunction

	// architectural state
	reg [31:0] vbase_secure;
	reg [31:0] vbase_nonsecure;
	reg [31:0] monitor_vector_base;
	reg [31:0] virtual_interrupt_pending;
	reg [31:0] user_rw_thread_slot;
	reg [31:0] user_ro_thread_slot;
	reg [31:0] privileged_thread_slot;
	reg [`TLB_IDX_W-1:0] tlb_read_index;
	reg [`TLB_IDX_W-1:0] tlb_write_index;
	reg [31:0] lockdown_virtual_tag;
	reg [31:0] lockdown_entry_attributes;
	// lockdown store, one word of each kind per entry
	reg [31:0] tlb_vtag_mem [0:`TLB_ENTRIES-1];
	reg [31:0] tlb_pa_mem [0:`TLB_ENTRIES-1];
	reg [31:0] tlb_attr_mem [0:`TLB_ENTRIES-1];

	wire [3:0] sel;
	wire sec_priv;
	reg allowed;
	reg [31:0] next_rdata;
	wire do_write;
	wire [2:0] virt_bits;

	assign sel = decode_sel(cp_opc1_i, cp_crn_i, cp_crm_i, cp_opc2_i);
	assign sec_priv = secure_i && privileged_i;

	// permission per register and direction
	always @*
	begin
		allowed = 1'b0;
		case (sel)
			`SEL_VBASE: allowed = privileged_i &&
				!(cp_write_i && secure_i && secure_write_lock_input_i);
			`SEL_MON_BASE: allowed = sec_priv &&
				!(cp_write_i && secure_write_lock_input_i);
			`SEL_VIRT_IRQ: allowed = sec_priv;
			`SEL_FAST_PID: allowed = privileged_i;
			`SEL_CONTEXT: allowed = privileged_i;
			`SEL_THREAD_URW: allowed = 1'b1;
			`SEL_THREAD_URO: allowed = privileged_i || !cp_write_i;
			`SEL_THREAD_PRW: allowed = privileged_i;
			`SEL_CFG_BASE: allowed = privileged_i || !cp_write_i;
			`SEL_TLB_RD_IDX: allowed = privileged_i && cp_write_i;
			`SEL_TLB_WR_IDX: allowed = privileged_i && cp_write_i;
			`SEL_TLB_VTAG: allowed = privileged_i;
			`SEL_TLB_PA: allowed = privileged_i;
			`SEL_TLB_ATTR: allowed = privileged_i;
			default: allowed = 1'b0;
		endcase
	end

	assign do_write = cp_valid_i && cp_write_i && allowed;

	// read data mux; lockdown reads come from the read-selected entry
	always @*
	begin
		next_rdata = 32'h00000000;
		case (sel)
			`SEL_VBASE: next_rdata = secure_i ? vbase_secure :
				vbase_nonsecure;
			`SEL_MON_BASE: next_rdata = monitor_vector_base;
			`SEL_VIRT_IRQ: next_rdata = virtual_interrupt_pending;
			`SEL_FAST_PID: next_rdata = 32'h00000000;
			`SEL_CONTEXT: next_rdata = context_identifier_o;
			`SEL_THREAD_URW: next_rdata = user_rw_thread_slot;
			`SEL_THREAD_URO: next_rdata = user_ro_thread_slot;
			`SEL_THREAD_PRW: next_rdata = privileged_thread_slot;
			`SEL_CFG_BASE: next_rdata = `CFG_BASE_VALUE;
			`SEL_TLB_VTAG: next_rdata = tlb_vtag_mem[tlb_read_index];
			`SEL_TLB_PA: next_rdata = tlb_pa_mem[tlb_read_index];
			`SEL_TLB_ATTR: next_rdata = tlb_attr_mem[tlb_read_index];
			default: next_rdata = 32'h00000000;
		endcase
	end

	// move answer, one cycle after the request
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			cp_done_o <= 1'b0;
			cp_undef_o <= 1'b0;
			cp_rdata_o <= 32'h00000000;
		end
		else
		begin
			cp_done_o <= cp_valid_i;
			cp_undef_o <= cp_valid_i && !allowed;
			if (cp_valid_i && !cp_write_i && allowed)
				cp_rdata_o <= next_rdata;
		end
	end

	// register writes; fast pid and config base swallow writes
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			vbase_secure <= `VBASE_SECURE_RESET;
			vbase_nonsecure <= 32'h00000000;
			monitor_vector_base <= 32'h00000000;
			virtual_interrupt_pending <= 32'h00000000;
			context_identifier_o <= 32'h00000000;
			user_rw_thread_slot <= 32'h00000000;
			user_ro_thread_slot <= 32'h00000000;
			privileged_thread_slot <= 32'h00000000;
			tlb_read_index <= {`TLB_IDX_W{1'b0}};
			tlb_write_index <= {`TLB_IDX_W{1'b0}};
			lockdown_virtual_tag <= 32'h00000000;
			lockdown_entry_attributes <= 32'h00000000;
		end
		else if (do_write)
		begin
			case (sel)
				`SEL_VBASE:
					if (secure_i)
						vbase_secure <= cp_wdata_i & `BASE_MASK;
					else
						vbase_nonsecure <= cp_wdata_i & `BASE_MASK;
				`SEL_MON_BASE:
					monitor_vector_base <= cp_wdata_i &
						`BASE_MASK;
				`SEL_VIRT_IRQ:
					virtual_interrupt_pending <= cp_wdata_i &
						`VIRT_MASK;
				`SEL_CONTEXT: context_identifier_o <= cp_wdata_i;
				`SEL_THREAD_URW: user_rw_thread_slot <= cp_wdata_i;
				`SEL_THREAD_URO: user_ro_thread_slot <= cp_wdata_i;
				`SEL_THREAD_PRW: privileged_thread_slot <= cp_wdata_i;
				`SEL_TLB_RD_IDX:
					tlb_read_index <= cp_wdata_i[`TLB_IDX_W-1:0];
				`SEL_TLB_WR_IDX:
					tlb_write_index <= cp_wdata_i[`TLB_IDX_W-1:0];
				`SEL_TLB_VTAG:
					lockdown_virtual_tag <= cp_wdata_i &
						`TLB_VTAG_MASK;
				`SEL_TLB_ATTR:
					lockdown_entry_attributes <= cp_wdata_i &
						`TLB_ATTR_MASK;
				default:
					context_identifier_o <= context_identifier_o;
			endcase
		end
	end

	// pa write commits staged tag and attributes as one whole page
	always @(posedge clk_i)
	begin
		if (do_write && sel == `SEL_TLB_PA)
		begin
			tlb_vtag_mem[tlb_write_index] <= lockdown_virtual_tag;
			tlb_pa_mem[tlb_write_index] <= cp_wdata_i;
			tlb_attr_mem[tlb_write_index] <= lockdown_entry_attributes;
		end
	end

	// tag output follows the low byte of the context id
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
			address_space_tag_o <= 8'h00;
		else
			address_space_tag_o <= context_identifier_o[7:0];
	end

	// virtual events reach the core only in the non-secure world
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1)
		begin : g_virt
			assign virt_bits[g] = virtual_interrupt_pending[
				`VIRT_FIQ_BIT + g] && !secure_i;
		end
	endgenerate

	// registered so the core sees a clean level
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			pending_guest_fiq_o <= 1'b0;
			pending_guest_irq_o <= 1'b0;
			pending_guest_abort_o <= 1'b0;
		end
		else
		begin
			pending_guest_fiq_o <= virt_bits[0];
			pending_guest_irq_o <= virt_bits[1];
			pending_guest_abort_o <= virt_bits[2];
		end
	end

	// branch target formation
	exc_vector_former u_vec
	(
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.exc_valid_i(exc_valid_i),
		.exc_kind_i(exc_kind_i),
		.exc_external_i(exc_external_i),
		.secure_i(secure_i),
		.high_vectors_i(high_vectors_i),
		.route_irq_mon_i(route_irq_mon_i),
		.route_fiq_mon_i(route_fiq_mon_i),
		.route_abort_mon_i(route_abort_mon_i),
		.vbase_secure_i(vbase_secure),
		.vbase_nonsecure_i(vbase_nonsecure),
		.mon_base_i(monitor_vector_base),
		.target_valid_o(target_valid_o),
		.target_monitor_o(target_monitor_o),
		.target_addr_o(target_addr_o)
	);
endmodule

//--- bench/cp_pipe_model.sv
// pipeline model issuing coprocessor moves to the register bank
`timescale 1ns/100ps
module cp_pipe_model
(
	// clock
	input wire clk_i,
	// move request
	output reg cp_valid_o = 1'b0,
	output reg cp_write_o = 1'b0,
	output reg [2:0] cp_opc1_o = 3'h0,
	output reg [3:0] cp_crn_o = 4'h0,
	output reg [3:0] cp_crm_o = 4'h0,
	output reg [2:0] cp_opc2_o = 3'h0,
	output reg [31:0] cp_wdata_o = 32'h0,
	// move answer
	input wire cp_done_i,
	input wire cp_undef_i,
	input wire [31:0] cp_rdata_i
);
	// one move launched after a falling edge; the answer stands one cycle
	task move(input w, input [13:0] e, input [31:0] d, output [1:0] a,
		output [31:0] r);
	begin
		@(negedge clk_i);
		cp_valid_o = 1'b1;
		cp_write_o = w;
		cp_opc1_o = e[13:11];
		cp_crn_o = e[10:7];
		cp_crm_o = e[6:3];
		cp_opc2_o = e[2:0];
		cp_wdata_o = d;
		@(negedge clk_i);
		a = {cp_done_i, cp_undef_i};
		r = cp_rdata_i;
		cp_valid_o = 1'b0;
		// released write and data lines flip so a stale value never looks valid
		cp_wdata_o = ~d;
		cp_write_o = ~w;
	end
	endtask
endmodule

//--- bench/vector_context_sysctl_regs_asserts.sv
// timing and access checks on the vector and context register bank
`timescale 1ns/100ps
module vecctx_checker
(
	// watched ports
	input wire clk_i,
	input wire rst_n_i,
	input wire cp_valid_i,
	input wire cp_write_i,
	input wire [2:0] cp_opc1_i,
	input wire [3:0] cp_crn_i,
	input wire [3:0] cp_crm_i,
	input wire [2:0] cp_opc2_i,
	input wire privileged_i,
	input wire secure_i,
	input wire secure_write_lock_input_i,
	input wire high_vectors_i,
	input wire exc_valid_i,
	input wire [2:0] exc_kind_i,
	input wire cp_done_o,
	input wire cp_undef_o,
	input wire [31:0] cp_rdata_o,
	input wire target_valid_o,
	input wire target_monitor_o,
	input wire [31:0] target_addr_o,
	input wire pending_guest_irq_o,
	input wire [7:0] address_space_tag_o,
	input wire [31:0] context_identifier_o
);
	// packed move encoding, opc1 crn crm opc2
	wire [13:0] enc = {cp_opc1_i, cp_crn_i, cp_crm_i, cp_opc2_i};
	wire sp = secure_i && privileged_i;
	default clocking core_clk @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	a_move_answered: assert property (cp_valid_i |=> cp_done_o)
		else $error("move not answered next cycle");
	a_no_stray_done: assert property (!cp_valid_i |=> !cp_done_o)
		else $error("answer without a move");
	a_mon_base_guard: assert property (
		cp_valid_i && enc == 14'h0601 && !sp |=> cp_undef_o)
		else $error("monitor base reached outside secure priv");
	a_mon_lock_write: assert property (
		cp_valid_i && enc == 14'h0601 && sp && cp_write_i
		&& secure_write_lock_input_i |=> cp_undef_o)
		else $error("locked monitor base write accepted");
	a_fast_pid_zero: assert property (
		cp_valid_i && enc == 14'h0680 && !cp_write_i && privileged_i
		|=> !cp_undef_o && cp_rdata_o == 32'h0)
		else $error("fast switch id not zero");
	a_cfg_base_fixed: assert property (
		cp_valid_i && enc == 14'h07A0 && !cp_write_i
		|=> !cp_undef_o && cp_rdata_o == 32'h0)
		else $error("configuration base read wrong");
	a_thread_ro_user: assert property (
		cp_valid_i && enc == 14'h0683 && cp_write_i && !privileged_i
		|=> cp_undef_o)
		else $error("user write to read-only slot accepted");
	a_virt_nonsecure: assert property (pending_guest_irq_o |->
		!$past(secure_i)) else $error("virtual irq in secure state");
	a_high_vector: assert property (exc_valid_i && high_vectors_i
		&& exc_kind_i == 3'h1 |=> target_valid_o && !target_monitor_o
		&& target_addr_o == 32'hFFFF0004) else $error("high vector wrong");
	a_reset_vector: assert property (exc_valid_i && !high_vectors_i
		&& exc_kind_i == 3'h0 |=> target_valid_o
		&& target_addr_o == 32'h0)
		else $error("reset vector not zero");
	a_tag_tracks: assert property (address_space_tag_o ==
		$past(context_identifier_o[7:0]))
		else $error("tag not context low byte");
	// main scenarios reached
	c_monitor_exc: cover property (target_valid_o && target_monitor_o);
	c_lockdown_pa: cover property (cp_valid_i && enc == 14'h2FB2 && cp_write_i);
	c_virt_irq: cover property (pending_guest_irq_o);
endmodule
bind vector_context_sysctl_regs vecctx_checker i_vecctx_checker (.clk_i,
	.rst_n_i, .cp_valid_i, .cp_write_i, .cp_opc1_i, .cp_crn_i, .cp_crm_i,
	.cp_opc2_i, .privileged_i, .secure_i, .secure_write_lock_input_i,
	.high_vectors_i, .exc_valid_i, .exc_kind_i, .cp_done_o, .cp_undef_o,
	.cp_rdata_o, .target_valid_o, .target_monitor_o, .target_addr_o,
	.pending_guest_irq_o, .address_space_tag_o, .context_identifier_o);

//--- bench/vector_context_sysctl_regs_tb.sv
// self-checking bench for the vector and context register bank
`timescale 1ns/100ps
module vector_context_sysctl_regs_tb;
	// packed encodings opc1 crn crm opc2
	localparam [13:0] VBASE = 14'h0600, MON = 14'h0601, VIRT = 14'h0609;
	localparam [13:0] FPID = 14'h0680, CTX = 14'h0681, CFG = 14'h07A0;
	localparam [13:0] RSEL = 14'h2FA2, WSEL = 14'h2FA4, VTAG = 14'h2FAA;
	localparam [13:0] PA = 14'h2FB2, ATTR = 14'h2FBA, BAD = 14'h0610;
	reg clk_i = 1'b0, rst_n_i = 1'b0, privileged_i = 1'b1, secure_i = 1'b1;
	reg lock = 1'b0, hv = 1'b0, exc_valid_i = 1'b0, exc_ext = 1'b0;
	reg r_irq = 1'b0, r_fiq = 1'b0, r_abt = 1'b0;
	reg [2:0] exc_kind_i = 3'h0, i;
	integer n_mismatch = 0, checks_done = 0;
	wire cp_valid, cp_write, cp_done, cp_undef, t_valid, t_mon, g_abt, g_irq;
	wire g_fiq;
	wire [2:0] opc1, opc2;
	wire [3:0] crn, crm;
	wire [7:0] tag;
	wire [31:0] wdata, rdata, t_addr, ctx_id;
	cp_pipe_model i_cp_pipe_model (.clk_i(clk_i), .cp_valid_o(cp_valid),
		.cp_write_o(cp_write), .cp_opc1_o(opc1), .cp_crn_o(crn),
		.cp_crm_o(crm), .cp_opc2_o(opc2), .cp_wdata_o(wdata),
		.cp_done_i(cp_done), .cp_undef_i(cp_undef), .cp_rdata_i(rdata));
	vector_context_sysctl_regs i_vector_context_sysctl_regs (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .cp_valid_i(cp_valid), .cp_write_i(cp_write),
		.cp_opc1_i(opc1), .cp_crn_i(crn), .cp_crm_i(crm), .cp_opc2_i(opc2),
		.cp_wdata_i(wdata), .privileged_i(privileged_i), .secure_i(secure_i),
		.secure_write_lock_input_i(lock), .high_vectors_i(hv),
		.exc_valid_i(exc_valid_i), .exc_kind_i(exc_kind_i),
		.exc_external_i(exc_ext), .route_irq_mon_i(r_irq),
		.route_fiq_mon_i(r_fiq), .route_abort_mon_i(r_abt),
		.cp_done_o(cp_done), .cp_undef_o(cp_undef), .cp_rdata_o(rdata),
		.target_valid_o(t_valid), .target_monitor_o(t_mon),
		.target_addr_o(t_addr), .pending_guest_abort_o(g_abt),
		.pending_guest_irq_o(g_irq), .pending_guest_fiq_o(g_fiq),
		.address_space_tag_o(tag), .context_identifier_o(ctx_id));
	// 250 MHz core clock
	initial
	begin
		forever #2 clk_i = ~clk_i;
	end
	task cmp(input [31:0] got, input [31:0] exp);
	begin
		checks_done = checks_done + 1;
		if (got !== exp)
		begin
			n_mismatch = n_mismatch + 1;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	// read data is compared only on accepted reads; refusals hold it
	task mv(input w, input [13:0] e, input [31:0] d, input u,
		input [31:0] x);
		reg [1:0] a;
		reg [31:0] r;
	begin
		i_cp_pipe_model.move(w, e, d, a, r);
		cmp({30'h0, a}, {30'h0, 1'b1, u});
		if (!w && !u)
			cmp(r, x);
	end
	endtask
	task ex(input [2:0] k, input xt, input mo, input [31:0] x);
	begin
		@(negedge clk_i);
		exc_valid_i = 1'b1;
		exc_kind_i = k;
		exc_ext = xt;
		@(negedge clk_i);
		exc_valid_i = 1'b0;
		cmp({30'h0, t_valid, t_mon}, {30'h0, 1'b1, mo});
		cmp(t_addr, x);
	end
	endtask
	task results;
	begin
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask
	// watchdog, far beyond the roughly 160 cycles the run needs
	initial
	begin
		#20000;
		n_mismatch = n_mismatch + 1;
		results;
	end
	initial
	begin
		repeat (4) @(negedge clk_i);
		rst_n_i = 1'b1;
		mv(1'b0, VBASE, 32'h0, 1'b0, 32'h0);
		mv(1'b1, VBASE, 32'h0000101F, 1'b0, 32'h0);
		mv(1'b0, VBASE, 32'h0, 1'b0, 32'h00001000);
		mv(1'b1, MON, 32'h8765432F, 1'b0, 32'h0);
		mv(1'b0, MON, 32'h0, 1'b0, 32'h87654320);
		{r_irq, r_fiq, r_abt} = 3'h7;
		ex(3'h0, 1'b0, 1'b0, 32'h0);
		ex(3'h1, 1'b0, 1'b0, 32'h00001004);
		ex(3'h2, 1'b0, 1'b0, 32'h00001008);
		ex(3'h3, 1'b0, 1'b0, 32'h0000100C);
		ex(3'h4, 1'b1, 1'b1, 32'h87654330);
		ex(3'h4, 1'b0, 1'b0, 32'h00001010);
		ex(3'h5, 1'b0, 1'b1, 32'h87654338);
		ex(3'h6, 1'b0, 1'b1, 32'h8765433C);
		ex(3'h7, 1'b0, 1'b1, 32'h87654328);
		{r_irq, r_fiq, r_abt} = 3'h0;
		ex(3'h5, 1'b0, 1'b0, 32'h00001018);
		ex(3'h6, 1'b0, 1'b0, 32'h0000101C);
		hv = 1'b1;
		ex(3'h1, 1'b0, 1'b0, 32'hFFFF0004);
		ex(3'h0, 1'b0, 1'b0, 32'hFFFF0000);
		ex(3'h7, 1'b0, 1'b1, 32'h87654328);
		hv = 1'b0;
		secure_i = 1'b0;
		mv(1'b1, VBASE, 32'h00002000, 1'b0, 32'h0);
		ex(3'h2, 1'b0, 1'b0, 32'h00002008);
		mv(1'b0, MON, 32'h0, 1'b1, 32'h0);
		mv(1'b1, VIRT, 32'h000001C0, 1'b1, 32'h0);
		secure_i = 1'b1;
		ex(3'h2, 1'b0, 1'b0, 32'h00001008);
		lock = 1'b1;
		mv(1'b1, MON, 32'h11111100, 1'b1, 32'h0);
		mv(1'b0, MON, 32'h0, 1'b0, 32'h87654320);
		lock = 1'b0;
		mv(1'b1, VIRT, 32'hFFFFFFFF, 1'b0, 32'h0);
		mv(1'b0, VIRT, 32'h0, 1'b0, 32'h000001C0);
		cmp({29'h0, g_abt, g_irq, g_fiq}, 32'h0);
		secure_i = 1'b0;
		@(negedge clk_i);
		cmp({29'h0, g_abt, g_irq, g_fiq}, 32'h7);
		secure_i = 1'b1;
		@(negedge clk_i);
		cmp({29'h0, g_abt, g_irq, g_fiq}, 32'h0);
		// bit 8 alone shows that the abort bit lands on its own output
		mv(1'b1, VIRT, 32'h00000100, 1'b0, 32'h0);
		secure_i = 1'b0;
		@(negedge clk_i);
		cmp({29'h0, g_abt, g_irq, g_fiq}, 32'h4);
		secure_i = 1'b1;
		mv(1'b1, VIRT, 32'h0, 1'b0, 32'h0);
		mv(1'b1, FPID, 32'hFFFFFFFF, 1'b0, 32'h0);
		mv(1'b0, FPID, 32'h0, 1'b0, 32'h0);
		// barriers and cache flush around the change are software's job
		mv(1'b1, CTX, 32'h12345678, 1'b0, 32'h0);
		cmp(ctx_id, 32'h12345678);
		mv(1'b0, CTX, 32'h0, 1'b0, 32'h12345678);
		cmp({24'h0, tag}, 32'h00000078);
		for (i = 3'h2; i < 3'h5; i = i + 3'h1)
		begin
			mv(1'b1, FPID + {11'h0, i}, 32'h5A000000 + i, 1'b0,
				32'h0);
			mv(1'b0, FPID + {11'h0, i}, 32'h0, 1'b0,
				32'h5A000000 + i);
		end
		privileged_i = 1'b0;
		for (i = 3'h2; i < 3'h5; i = i + 3'h1)
		begin
			mv(1'b1, FPID + {11'h0, i}, 32'h1, i != 3'h2, 32'h0);
			mv(1'b0, FPID + {11'h0, i}, 32'h0, i == 3'h4,
				(i == 3'h2) ? 32'h1 : 32'h5A000003);
		end
		mv(1'b0, MON, 32'h0, 1'b1, 32'h0);
		mv(1'b0, CTX, 32'h0, 1'b1, 32'h0);
		mv(1'b0, CFG, 32'h0, 1'b0, 32'h0);
		mv(1'b1, CFG, 32'hFFFFFFFF, 1'b1, 32'h0);
		mv(1'b1, WSEL, 32'h3, 1'b1, 32'h0);
		privileged_i = 1'b1;
		mv(1'b1, CFG, 32'hFFFFFFFF, 1'b0, 32'h0);
		mv(1'b0, CFG, 32'h0, 1'b0, 32'h0);
		mv(1'b1, WSEL, 32'h3, 1'b0, 32'h0);
		mv(1'b1, VTAG, 32'hFFFFFFFF, 1'b0, 32'h0);
		mv(1'b1, ATTR, 32'hFFFFFFFF, 1'b0, 32'h0);
		mv(1'b1, PA, 32'hABCDE000, 1'b0, 32'h0);
		mv(1'b1, WSEL, 32'h5, 1'b0, 32'h0);
		mv(1'b1, VTAG, 32'h00001200, 1'b0, 32'h0);
		mv(1'b1, ATTR, 32'h00000005, 1'b0, 32'h0);
		mv(1'b1, PA, 32'h00001000, 1'b0, 32'h0);
		mv(1'b1, RSEL, 32'h3, 1'b0, 32'h0);
		mv(1'b0, VTAG, 32'h0, 1'b0, 32'hFFFFF7FF);
		mv(1'b0, ATTR, 32'h0, 1'b0, 32'h00000FFF);
		mv(1'b0, PA, 32'h0, 1'b0, 32'hABCDE000);
		mv(1'b1, RSEL, 32'h5, 1'b0, 32'h0);
		mv(1'b0, VTAG, 32'h0, 1'b0, 32'h00001200);
		mv(1'b0, ATTR, 32'h0, 1'b0, 32'h00000005);
		mv(1'b0, PA, 32'h0, 1'b0, 32'h00001000);
		mv(1'b0, RSEL, 32'h0, 1'b1, 32'h0);
		mv(1'b0, BAD, 32'h0, 1'b1, 32'h0);
		mv(1'b1, BAD, 32'h0, 1'b1, 32'h0);
		// second reset mid-run; the written secure base must drop to zero
		rst_n_i = 1'b0;
		repeat (2) @(negedge clk_i);
		rst_n_i = 1'b1;
		mv(1'b0, VBASE, 32'h0, 1'b0, 32'h0);
		mv(1'b0, CTX, 32'h0, 1'b0, 32'h0);
		results;
	end
endmodule
